// ==== rtl/ssf_supervisor.sv ====
// ssf_supervisor: supply supervision flags, reset and fail outputs
// assumes filtered, synchronous comparator inputs;
// watchdog core and command decoder sit outside.
// Functional notes
// - stop bus wake starts off watchdog, long window
// - start enable writable only in normal mode
// - stop bus wake: interrupt, receive pin low
// - power-on sets flag, defaults; reset held to release
// - supply below power-on: internal reset, restart in init
// - battery undervoltage sets only its flag
// - battery undervoltage disables short protection only
// - stop battery monitor only with peak load or prewarning
// - battery overvoltage in active modes or charge pump
// - main prewarning only sets its flag
// - main below threshold: reset, restart, flag at release
// - boosted hysteresis releases at top rising threshold
// - overvoltage reset, state one: restart, fail, resume normal
// - overvoltage reset, state zero: fail-safe, fail output
// - main not up in filter time: short response, fail-safe
// - main low past filter time same; wakes reactivate
// - aux undervoltage flag blanked, bus supply undervoltage flag unblanked
// - thermal shutdown only while block on
// - aux overtemperature clears enables, sets flag
// - bus overtemperature stops transmitter, field one, resumes
// - thermal prewarning flag clears on host request, only once gone
// - watchdog trigger three cycles after chip select rise
`default_nettype none
`include "ssf_params.svh"
module ssf_supervisor
  import ssf_pkg::*;
#(
  parameter int unsigned RESET_DLY_CYC =
    `SSF_T_RESET_DLY_US * `SSF_CLK_MHZ,
  parameter int unsigned SHORT_FILT_CYC =
    `SSF_T_SHORT_US * `SSF_CLK_MHZ,
  parameter int unsigned AUX_BLANK_CYC =
    `SSF_T_AUX_BLANK_US * `SSF_CLK_MHZ
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_out_n,
  input  wire logic        i_batt_above_por,
  input  wire logic        i_batt_undervolt,
  input  wire logic        i_batt_overvolt,
  input  wire logic        i_charge_pump_on,
  input  wire logic        i_peak_load,
  input  wire logic        i_main_prewarn,
  input  wire logic        i_main_below_reset,
  input  wire logic        i_main_above_rise_sel,
  input  wire logic        i_main_above_rise_top,
  input  wire logic        i_main_overvolt,
  input  wire logic        i_aux_undervolt,
  input  wire logic        i_bus_on,
  input  wire logic        i_bus_supply_undervolt,
  input  wire logic        i_aux_overtemp,
  input  wire logic        i_bus_overtemp,
  input  wire logic        i_thermal_prewarn,
  input  wire logic        i_bus_wake,
  input  wire logic        i_wake_input,
  input  wire logic        i_gpio_wake,
  input  wire logic        i_wdog_off,
  input  wire logic        i_req_normal,
  input  wire logic        i_req_stop,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_wake_wdog_start_val,
  input  wire logic        i_hys_boost_val,
  input  wire logic        i_ov_reset_val,
  input  wire logic        i_aux_en_wr,
  input  wire logic [1:0]  i_aux_en_val,
  input  wire logic        i_config_state_bit,
  input  wire ssf_flags_t  i_flag_clr,
  input  wire logic        i_bus_fail_clr,
  input  wire logic        i_wdog_cfg_cs_rise,
  output ssf_mode_t        o_mode,
  output ssf_flags_t       o_flags,
  output logic [1:0]       o_bus_fail_field,
  output logic             o_reset_out_n,
  output logic             o_fail_output,
  output logic             o_main_reg_en,
  output logic [1:0]       o_aux_enable_bits,
  output logic             o_bus_tx_en,
  output logic             o_main_short_prot_en,
  output logic             o_batt_mon_active,
  output logic             o_wake_irq,
  output logic             o_bus_rxd_low,
  output logic             o_wdog_long_window,
  output logic             o_wdog_trigger,
  output logic             o_bus_wake_wdog_start_en,
  output logic             o_reset_hysteresis_boost,
  output logic             o_main_overvolt_reset_en
);
  import ssf_pkg::*;

  localparam logic [`SSF_CNT_W-1:0] RD_LIM =
    `SSF_CNT_W'(RESET_DLY_CYC - 1);
  localparam logic [`SSF_CNT_W-1:0] SC_LIM =
    `SSF_CNT_W'(SHORT_FILT_CYC - 1);
  localparam logic [`SSF_CNT_W-1:0] BL_LIM =
    `SSF_CNT_W'(AUX_BLANK_CYC - 1);

  ssf_mode_t  mode;
  ssf_mode_t  next_mode;
  logic       rst_low;
  logic       next_rst_low;
  logic       fail_out;
  logic       next_fail_out;
  logic       main_en;
  logic       next_main_en;
  logic       first_up;
  logic       next_first_up;
  logic       ov_restart;
  logic       next_ov_restart;
  logic       uv_restart;
  logic       next_uv_restart;
  logic       rxd_low;
  logic       next_rxd_low;
  logic       irq;
  logic       next_irq;
  logic       wd_long;
  logic       next_wd_long;
  logic       wake_start_en;
  logic       next_wake_start_en;
  logic       hys_boost;
  logic       next_hys_boost;
  logic       ov_rst_en;
  logic       next_ov_rst_en;
  logic [1:0] aux_en;
  logic [1:0] next_aux_en;
  logic [1:0] aux_en_d;
  logic [1:0] bus_fail;
  logic [1:0] next_bus_fail;
  logic [`SSF_TRIG_DLY_CYC-1:0] trig_sr;
  logic [`SSF_TRIG_DLY_CYC-1:0] next_trig_sr;
  ssf_flags_t flags;
  ssf_flags_t next_flags;
  ssf_flags_t cause;

  logic blank_done_q;
  logic next_blank_done_q;
  logic rd_done;
  logic sc_done;
  logic blank_done;
  logic release_ok;
  logic sc_run;
  logic aux_on;
  logic mon_active;
  logic ov_mon;
  logic short_evt;
  logic ov_evt;
  logic any_wake;

  // set beats clear; a clear lands only once cause is gone
  function automatic logic sticky(input logic q, input logic set,
                                  input logic clr, input logic busy);
    sticky = set || (q && !(clr && !busy));
  endfunction : sticky

  assign aux_on     = |aux_en;
  // low battery resets the short timer; thermal untouched
  assign o_main_short_prot_en = !i_batt_undervolt;
  assign sc_run     = main_en && i_main_below_reset
                      && !i_batt_undervolt && mode != SSF_FAILSAFE;
  // top threshold at power-up or with boosted hysteresis
  assign release_ok = ov_restart
                      || ((hys_boost || first_up) ? i_main_above_rise_top
                                                  : i_main_above_rise_sel);
  assign mon_active = (mode == SSF_INIT) || (mode == SSF_RESTART)
                      || (mode == SSF_NORMAL)
                      || (mode == SSF_STOP
                          && (i_peak_load || i_main_prewarn));
  assign ov_mon     = mon_active || i_charge_pump_on;
  assign short_evt  = sc_done;
  assign ov_evt     = main_en && i_main_overvolt && ov_rst_en
                      && mode != SSF_FAILSAFE && !ov_restart;
  assign any_wake   = i_bus_wake || i_wake_input || i_gpio_wake;

  ssf_timer u_reset_dly (
    .i_sys_clk (i_sys_clk),
    .i_reset_out_n    (i_reset_out_n),
    .i_run     (rst_low && release_ok && main_en),
    .i_limit   (RD_LIM),
    .o_done    (rd_done)
  );

  ssf_timer u_short_filt (
    .i_sys_clk (i_sys_clk),
    .i_reset_out_n    (i_reset_out_n),
    .i_run     (sc_run),
    .i_limit   (SC_LIM),
    .o_done    (sc_done)
  );

  // blanking follows any aux enable change
  ssf_timer u_aux_blank (
    .i_sys_clk (i_sys_clk),
    .i_reset_out_n    (i_reset_out_n),
    .i_run     (aux_en == aux_en_d && !blank_done_q),
    .i_limit   (BL_LIM),
    .o_done    (blank_done)
  );

  // mode, reset and fail output
  always_comb begin
    next_mode       = mode;
    next_rst_low    = rst_low;
    next_fail_out   = fail_out;
    next_main_en    = main_en;
    next_first_up   = first_up;
    next_ov_restart = ov_restart;
    next_uv_restart = uv_restart;
    next_rxd_low    = rxd_low;
    next_irq        = 1'b0;
    next_wd_long    = 1'b0;
    if (!i_batt_above_por) begin
      next_mode       = SSF_INIT;
      next_rst_low    = 1'b1;
      next_fail_out   = 1'b0;
      next_main_en    = 1'b1;
      next_first_up   = 1'b1;
      next_ov_restart = 1'b0;
      next_uv_restart = 1'b0;
      next_rxd_low    = 1'b0;
    end else begin
      unique case (mode)
        SSF_INIT, SSF_RESTART: begin
          if (rd_done) begin
            next_rst_low    = 1'b0;
            next_first_up   = 1'b0;
            next_ov_restart = 1'b0;
            next_uv_restart = 1'b0;
            if (mode == SSF_RESTART) begin
              next_mode = SSF_NORMAL;
            end
          end else if (mode == SSF_INIT && !rst_low && i_req_normal) begin
            next_mode = SSF_NORMAL;
          end
        end
        SSF_NORMAL: begin
          if (i_req_stop) begin
            next_mode = SSF_STOP;
          end
        end
        SSF_STOP: begin
          if (i_bus_wake) begin
            next_irq     = 1'b1;
            next_rxd_low = 1'b1;
            next_wd_long = wake_start_en && i_wdog_off;
          end
          // a fresh disable sequence needs normal mode again
          if (i_req_normal) begin
            next_mode    = SSF_NORMAL;
            next_rxd_low = 1'b0;
          end
        end
        SSF_FAILSAFE: begin
          if (any_wake) begin
            next_mode    = SSF_RESTART;
            next_main_en = 1'b1;
            next_rst_low = 1'b1;
          end
        end
        default: begin
          next_mode = SSF_INIT;
        end
      endcase
      if (mode != SSF_FAILSAFE && main_en) begin
        if (short_evt) begin
          next_mode     = SSF_FAILSAFE;
          next_main_en  = 1'b0;
          next_fail_out = 1'b1;
          next_rst_low  = 1'b1;
          next_rxd_low  = 1'b0;
        end else if (ov_evt && !i_config_state_bit) begin
          next_mode     = SSF_FAILSAFE;
          next_fail_out = 1'b1;
          next_rst_low  = 1'b1;
          next_rxd_low  = 1'b0;
        end else if (ov_evt) begin
          next_mode       = SSF_RESTART;
          next_fail_out   = 1'b1;
          next_rst_low    = 1'b1;
          next_ov_restart = 1'b1;
          next_rxd_low    = 1'b0;
        end else if (i_main_below_reset && !rst_low) begin
          next_mode       = SSF_RESTART;
          next_rst_low    = 1'b1;
          next_uv_restart = 1'b1;
          next_rxd_low    = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_out_n) begin
    if (!i_reset_out_n) begin
      mode       <= SSF_INIT;
      rst_low    <= 1'b1;
      fail_out   <= 1'b0;
      main_en    <= 1'b1;
      first_up   <= 1'b1;
      ov_restart <= 1'b0;
      uv_restart <= 1'b0;
      rxd_low    <= 1'b0;
      irq        <= 1'b0;
      wd_long    <= 1'b0;
    end else begin
      mode       <= next_mode;
      rst_low    <= next_rst_low;
      fail_out   <= next_fail_out;
      main_en    <= next_main_en;
      first_up   <= next_first_up;
      ov_restart <= next_ov_restart;
      uv_restart <= next_uv_restart;
      rxd_low    <= next_rxd_low;
      irq        <= next_irq;
      wd_long    <= next_wd_long;
    end
  end

  // configuration bits written by the host
  always_comb begin
    next_wake_start_en = wake_start_en;
    next_hys_boost     = hys_boost;
    next_ov_rst_en     = ov_rst_en;
    next_aux_en        = aux_en;
    next_trig_sr       = {trig_sr[`SSF_TRIG_DLY_CYC-2:0],
                          i_wdog_cfg_cs_rise};
    next_blank_done_q  = (aux_en != aux_en_d) ? 1'b0
                         : (blank_done_q || blank_done);
    if (i_cfg_wr) begin
      next_hys_boost = i_hys_boost_val;
      next_ov_rst_en = i_ov_reset_val;
      if (mode == SSF_NORMAL) begin
        next_wake_start_en = i_wake_wdog_start_val;
      end
    end
    if (i_aux_en_wr) begin
      next_aux_en = i_aux_en_val;
    end
    if (aux_on && i_aux_overtemp) begin
      next_aux_en = `SSF_AUX_EN_OFF;
    end
    if (ov_evt && i_config_state_bit && mode != SSF_FAILSAFE) begin
      next_ov_rst_en = 1'b0;
    end
    if (!i_batt_above_por) begin
      next_wake_start_en = `SSF_WAKE_WDOG_RST;
      next_hys_boost     = 1'b0;
      next_ov_rst_en     = 1'b0;
      next_aux_en        = `SSF_AUX_EN_OFF;
      next_trig_sr       = '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_out_n) begin
    if (!i_reset_out_n) begin
      wake_start_en <= `SSF_WAKE_WDOG_RST;
      hys_boost     <= 1'b0;
      ov_rst_en     <= 1'b0;
      aux_en        <= `SSF_AUX_EN_OFF;
      aux_en_d      <= `SSF_AUX_EN_OFF;
      trig_sr       <= '0;
      blank_done_q  <= 1'b0;
    end else begin
      wake_start_en <= next_wake_start_en;
      hys_boost     <= next_hys_boost;
      ov_rst_en     <= next_ov_rst_en;
      aux_en        <= next_aux_en;
      aux_en_d      <= aux_en;
      trig_sr       <= next_trig_sr;
      blank_done_q  <= next_blank_done_q;
    end
  end

  // live causes; each flag sets only from its own cause
  always_comb begin
    cause = '0;
    cause.battery_undervolt_flag = mon_active && i_batt_undervolt;
    cause.battery_overvolt_flag  = ov_mon && i_batt_overvolt;
    cause.main_prewarn_flag  = main_en && i_main_prewarn;
    cause.main_overvolt_flag = main_en && i_main_overvolt;
    cause.main_short_flag    = short_evt;
    cause.failure            = short_evt;
    cause.aux_undervolt_flag = aux_on && i_aux_undervolt
                               && blank_done_q;
    cause.bus_supply_undervolt_flag = i_bus_on
                                      && i_bus_supply_undervolt;
    cause.aux_overtemp_flag  = aux_on && i_aux_overtemp;
    cause.block_thermal_shutdown_flag = (aux_on && i_aux_overtemp)
                                        || (i_bus_on && i_bus_overtemp);
    cause.thermal_prewarn_flag = i_thermal_prewarn;
  end

  always_comb begin
    next_flags = flags;
    next_flags.por = sticky(flags.por, 1'b0, i_flag_clr.por, 1'b0);
    next_flags.failure = sticky(flags.failure, cause.failure,
                                i_flag_clr.failure, 1'b0);
    next_flags.battery_undervolt_flag = sticky(
      flags.battery_undervolt_flag, cause.battery_undervolt_flag,
      i_flag_clr.battery_undervolt_flag, i_batt_undervolt);
    next_flags.battery_overvolt_flag = sticky(
      flags.battery_overvolt_flag, cause.battery_overvolt_flag,
      i_flag_clr.battery_overvolt_flag, cause.battery_overvolt_flag);
    next_flags.main_prewarn_flag = sticky(flags.main_prewarn_flag,
      cause.main_prewarn_flag, i_flag_clr.main_prewarn_flag,
      cause.main_prewarn_flag);
    next_flags.main_undervolt_flag = sticky(flags.main_undervolt_flag,
      uv_restart && rd_done, i_flag_clr.main_undervolt_flag,
      rst_low && uv_restart);
    next_flags.main_overvolt_flag = sticky(flags.main_overvolt_flag,
      cause.main_overvolt_flag, i_flag_clr.main_overvolt_flag,
      cause.main_overvolt_flag);
    next_flags.main_short_flag = sticky(flags.main_short_flag,
      cause.main_short_flag, i_flag_clr.main_short_flag, 1'b0);
    next_flags.aux_undervolt_flag = sticky(flags.aux_undervolt_flag,
      cause.aux_undervolt_flag, i_flag_clr.aux_undervolt_flag, 1'b0);
    next_flags.bus_supply_undervolt_flag = sticky(
      flags.bus_supply_undervolt_flag, cause.bus_supply_undervolt_flag,
      i_flag_clr.bus_supply_undervolt_flag, 1'b0);
    next_flags.block_thermal_shutdown_flag = sticky(
      flags.block_thermal_shutdown_flag,
      cause.block_thermal_shutdown_flag,
      i_flag_clr.block_thermal_shutdown_flag,
      i_aux_overtemp || i_bus_overtemp);
    next_flags.aux_overtemp_flag = sticky(flags.aux_overtemp_flag,
      cause.aux_overtemp_flag, i_flag_clr.aux_overtemp_flag,
      i_aux_overtemp);
    next_flags.thermal_prewarn_flag = sticky(flags.thermal_prewarn_flag,
      cause.thermal_prewarn_flag, i_flag_clr.thermal_prewarn_flag,
      i_thermal_prewarn);
    next_bus_fail = bus_fail;
    if (i_bus_fail_clr && !i_bus_overtemp) begin
      next_bus_fail = 2'h0;
    end
    if (i_bus_on && i_bus_overtemp) begin
      next_bus_fail = `SSF_BUS_FAIL_OT;
    end
    if (!i_batt_above_por) begin
      next_flags     = '0;
      next_flags.por = 1'b1;
      next_bus_fail  = 2'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_out_n) begin
    if (!i_reset_out_n) begin
      flags     <= '{por: 1'b1, default: 1'b0};
      bus_fail  <= 2'h0;
    end else begin
      flags     <= next_flags;
      bus_fail  <= next_bus_fail;
    end
  end

  assign o_mode                   = mode;
  assign o_flags                  = flags;
  assign o_bus_fail_field         = bus_fail;
  assign o_reset_out_n            = !rst_low;
  assign o_fail_output            = fail_out;
  assign o_main_reg_en            = main_en;
  assign o_aux_enable_bits        = aux_en;
  // transmitter comes back by itself once the block cools
  assign o_bus_tx_en              = i_bus_on && !i_bus_overtemp;
  assign o_batt_mon_active        = mon_active;
  assign o_wake_irq               = irq;
  assign o_bus_rxd_low            = rxd_low;
  assign o_wdog_long_window       = wd_long;
  assign o_wdog_trigger           = trig_sr[`SSF_TRIG_DLY_CYC-1];
  assign o_bus_wake_wdog_start_en = wake_start_en;
  assign o_reset_hysteresis_boost = hys_boost;
  assign o_main_overvolt_reset_en = ov_rst_en;
endmodule : ssf_supervisor
`default_nettype wire

// ==== rtl/ssf_params.svh ====
// ssf_params.svh: constants of the supervision block
// assumes a 50 MHz system clock; long counts are top-level parameters
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

`define SSF_CLK_MHZ        50
`define SSF_T_RESET_DLY_US 10000
`define SSF_T_SHORT_US     2000
`define SSF_T_AUX_BLANK_US 100
`define SSF_TRIG_DLY_CYC   3
`define SSF_CNT_W          20
`define SSF_WAKE_WDOG_RST  1'b1
`define SSF_BUS_FAIL_OT    2'h1
`define SSF_AUX_EN_OFF     2'h0

`endif

// ==== rtl/ssf_pkg.sv ====
// ssf_pkg: types shared by the supply supervision block
// assumes ssf_params.svh is compiled alongside
`default_nettype none
package ssf_pkg;
  typedef enum logic [2:0] {
    SSF_INIT, SSF_NORMAL, SSF_STOP, SSF_RESTART, SSF_FAILSAFE
  } ssf_mode_t;

  typedef struct packed {
    logic por;
    logic failure;
    logic battery_undervolt_flag;
    logic battery_overvolt_flag;
    logic main_prewarn_flag;
    logic main_undervolt_flag;
    logic main_overvolt_flag;
    logic main_short_flag;
    logic aux_undervolt_flag;
    logic bus_supply_undervolt_flag;
    logic block_thermal_shutdown_flag;
    logic aux_overtemp_flag;
    logic thermal_prewarn_flag;
  } ssf_flags_t;
endpackage : ssf_pkg
`default_nettype wire

// ==== rtl/ssf_timer.sv ====
// ssf_timer: up-counter that runs while enabled and flags its limit
// assumes i_run is synchronous to i_sys_clk
`default_nettype none
`include "ssf_params.svh"
module ssf_timer (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_out_n,
  input  wire logic                   i_run,
  input  wire logic [`SSF_CNT_W-1:0]  i_limit,
  output logic                        o_done
);
  logic [`SSF_CNT_W-1:0] cnt;
  logic [`SSF_CNT_W-1:0] next_cnt;

  // a drop of i_run restarts the count
  always_comb begin
    next_cnt = '0;
    if (i_run && cnt != i_limit) begin
      next_cnt = cnt + `SSF_CNT_W'(1);
    end else if (i_run) begin
      next_cnt = cnt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_out_n) begin
    if (!i_reset_out_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_done = i_run && (cnt == i_limit);
endmodule : ssf_timer
`default_nettype wire

// ==== dv/ssf_sup_props.sv ====
// ssf_sup_props: port checks of ssf_supervisor
// assumes binding to every instance
`default_nettype none
module ssf_sup_props
  import ssf_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_reset_out_n,
  input wire logic       i_batt_above_por,
  input wire logic       i_batt_undervolt,
  input wire logic       i_main_below_reset,
  input wire logic       i_main_overvolt,
  input wire logic       i_bus_on,
  input wire logic       i_bus_overtemp,
  input wire logic       i_thermal_prewarn,
  input wire logic       i_bus_wake,
  input wire logic       i_wdog_off,
  input wire logic       i_wdog_cfg_cs_rise,
  input wire ssf_flags_t i_flag_clr,
  input wire ssf_mode_t  o_mode,
  input wire ssf_flags_t o_flags,
  input wire logic [1:0] o_bus_fail_field,
  input wire logic       o_reset_out_n,
  input wire logic       o_bus_tx_en,
  input wire logic       o_main_short_prot_en,
  input wire logic       o_batt_mon_active,
  input wire logic       o_wake_irq,
  input wire logic       o_bus_rxd_low,
  input wire logic       o_wdog_long_window,
  input wire logic       o_wdog_trigger,
  input wire logic       o_bus_wake_wdog_start_en
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_out_n);
  AST_WDOG_TRIG: assert property (i_wdog_cfg_cs_rise |=> !o_wdog_trigger
    ##1 !o_wdog_trigger ##1 o_wdog_trigger) else $error("trigger");
  AST_SHORT_PROT: assert property (o_main_short_prot_en == !i_batt_undervolt)
    else $error("short prot");
  AST_BUS_TX: assert property (o_bus_tx_en == (i_bus_on && !i_bus_overtemp))
    else $error("tx enable");
  AST_BUS_FAIL: assert property (i_batt_above_por && i_bus_on && i_bus_overtemp
    |=> o_bus_fail_field == 2'h1) else $error("bus fail");
  AST_MAIN_UV: assert property (i_batt_above_por && o_reset_out_n &&
    i_main_below_reset && !i_main_overvolt && o_mode != SSF_RESTART
    |=> !o_reset_out_n && o_mode == SSF_RESTART) else $error("no uv restart");
  AST_POR: assert property (!i_batt_above_por |=> o_mode == SSF_INIT &&
    !o_reset_out_n && o_flags.por) else $error("no reset");
  AST_WAKE: assert property (i_batt_above_por && o_mode == SSF_STOP &&
    i_bus_wake |=> o_wake_irq && o_bus_rxd_low) else $error("no wake");
  AST_LONG_WIN: assert property (i_batt_above_por && o_mode == SSF_STOP &&
    i_bus_wake && i_wdog_off && o_bus_wake_wdog_start_en
    |=> o_wdog_long_window) else $error("no long window");
  AST_STICKY: assert property ($fell(o_flags.thermal_prewarn_flag) |->
    !$past(i_batt_above_por) || ($past(i_flag_clr.thermal_prewarn_flag) &&
    !$past(i_thermal_prewarn))) else $error("flag dropped");
  AST_MON: assert property (o_mode inside {SSF_INIT, SSF_NORMAL, SSF_RESTART}
    |-> o_batt_mon_active) else $error("monitor off");
endmodule : ssf_sup_props
bind ssf_supervisor ssf_sup_props u_props (.*);
`default_nettype wire

// ==== dv/ssf_host_model.sv ====
// ssf_host_model: host that clears flags, requests modes
// assumes launch at the falling edge
`default_nettype none
module ssf_host_model
  import ssf_pkg::*;
(
  input  wire logic      i_sys_clk,
  output var ssf_flags_t o_flag_clr,
  output var logic       o_req_normal,
  output var logic       o_req_stop,
  output var logic       o_cs_rise
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_flag_clr = '0;
    {o_req_normal, o_req_stop, o_cs_rise} = 3'h0;
  end
  // one-cycle pulses: a held request repeats
  task automatic send(input int kind, input ssf_flags_t mask);
    @(negedge i_sys_clk);
    case (kind)
      0: o_flag_clr = mask;
      1: o_req_normal = 1'h1;
      2: o_req_stop = 1'h1;
      default: o_cs_rise = 1'h1;
    endcase
    @(negedge i_sys_clk);
    o_flag_clr = '0;
    {o_req_normal, o_req_stop, o_cs_rise} = 3'h0;
  endtask : send
endmodule : ssf_host_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// tb_top: scenario bench for ssf_supervisor
// assumes short counts; inputs change at falling edge
`default_nettype none
module tb_top
  import ssf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  int miscompares = 0, tests_run = 0;
  logic i_sys_clk = 1'h0, i_reset_out_n = 1'h0, i_batt_above_por = 1'h1;
  logic i_batt_undervolt = 1'h0, i_batt_overvolt = 1'h0, i_peak_load = 1'h0;
  logic i_charge_pump_on = 1'h0, i_main_prewarn = 1'h0, i_bus_on = 1'h0;
  logic i_main_below_reset = 1'h0, i_main_above_rise_sel = 1'h0;
  logic i_main_above_rise_top = 1'h0, i_main_overvolt = 1'h0;
  logic i_aux_undervolt = 1'h0, i_bus_supply_undervolt = 1'h0;
  logic i_aux_overtemp = 1'h0, i_bus_overtemp = 1'h0, i_thermal_prewarn = 1'h0;
  logic i_bus_wake = 1'h0, i_wake_input = 1'h0, i_gpio_wake = 1'h0;
  logic i_wdog_off = 1'h0, i_cfg_wr = 1'h0, i_wake_wdog_start_val = 1'h1;
  logic i_hys_boost_val = 1'h0, i_ov_reset_val = 1'h0, i_aux_en_wr = 1'h0;
  logic i_config_state_bit = 1'h0, i_bus_fail_clr = 1'h0;
  logic i_req_normal, i_req_stop, i_wdog_cfg_cs_rise;
  logic [1:0] i_aux_en_val = 2'h0, o_bus_fail_field, o_aux_enable_bits;
  ssf_flags_t i_flag_clr, o_flags, b, m;
  ssf_mode_t o_mode;
  logic o_reset_out_n, o_fail_output, o_main_reg_en, o_bus_tx_en;
  logic o_main_short_prot_en, o_batt_mon_active, o_wake_irq, o_bus_rxd_low;
  logic o_wdog_long_window, o_wdog_trigger, o_bus_wake_wdog_start_en;
  logic o_reset_hysteresis_boost, o_main_overvolt_reset_en;
  int n;
  ssf_supervisor #(.RESET_DLY_CYC(8), .SHORT_FILT_CYC(8), .AUX_BLANK_CYC(4))
    DUT (.*);
  ssf_host_model host (.i_sys_clk, .o_flag_clr(i_flag_clr),
    .o_req_normal(i_req_normal), .o_req_stop(i_req_stop),
    .o_cs_rise(i_wdog_cfg_cs_rise));
  initial forever #10 i_sys_clk = ~i_sys_clk;
  task automatic close_out;
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk
  // bounded wait; n returns cycles spent
  task automatic await(input logic [3:0] mask, input logic [3:0] want);
    for (n = 0; ({o_reset_out_n, o_mode} & mask) !== want && n < 40; n++)
      @(negedge i_sys_clk);
    chk(n < 40, "timeout");
    if (n >= 40) close_out();
  endtask : await
  task automatic cause(input int k, input logic v);
    m = '0;
    case (k)
      0: {i_batt_undervolt, m.battery_undervolt_flag} = {v, 1'h1};
      1: {i_batt_overvolt, m.battery_overvolt_flag} = {v, 1'h1};
      2: {i_main_prewarn, m.main_prewarn_flag} = {v, 1'h1};
      3: {i_thermal_prewarn, m.thermal_prewarn_flag} = {v, 1'h1};
      default: {i_main_overvolt, m.main_overvolt_flag} = {v, 1'h1};
    endcase
  endtask : cause
  task automatic t_power_up;
    chk(o_flags.por && !o_reset_out_n && o_mode === SSF_INIT, "por");
    {i_main_above_rise_sel, i_main_above_rise_top} = 2'h3;
    await(4'h8, 4'h8);
    chk(n >= 8 && n <= 10 && o_mode === SSF_INIT, "reset delay");
    host.send(1, '0);
    chk(o_mode === SSF_NORMAL, "normal");
    host.send(3, '0);
    @(negedge i_sys_clk);
    chk(o_wdog_trigger === 1'h0, "early");
    @(negedge i_sys_clk);
    chk(o_wdog_trigger === 1'h1, "trigger");
    $display("end power_up");
  endtask : t_power_up
  task automatic t_flags;
    for (int k = 0; k < 5; k++) begin
      b = o_flags;
      cause(k, 1'h1);
      @(negedge i_sys_clk);
      chk((o_flags ^ b) === m, "own flag");
      host.send(0, m);
      chk((o_flags & m) === m, "clear refused");
      cause(k, 1'h0);
      host.send(0, m);
      chk((o_flags & m) === '0, "clear");
    end
    $display("end flags");
  endtask : t_flags
  task automatic t_bus_ot;
    {i_bus_on, i_bus_overtemp} = 2'h3;
    @(negedge i_sys_clk);
    chk(!o_bus_tx_en && o_bus_fail_field === 2'h1 &&
      o_flags.block_thermal_shutdown_flag, "bus overtemp");
    i_bus_overtemp = 1'h0;
    i_bus_fail_clr = 1'h1;
    @(negedge i_sys_clk);
    i_bus_fail_clr = 1'h0;
    chk(o_bus_tx_en && o_bus_fail_field === 2'h0, "bus resume");
    $display("end bus_ot");
  endtask : t_bus_ot
  task automatic t_stop_wake;
    i_wdog_off = 1'h1;
    host.send(2, '0);
    {i_cfg_wr, i_wake_wdog_start_val} = 2'h2;
    @(negedge i_sys_clk);
    i_cfg_wr = 1'h0;
    chk(o_mode === SSF_STOP && o_bus_wake_wdog_start_en, "cfg in stop");
    i_bus_wake = 1'h1;
    @(negedge i_sys_clk);
    i_bus_wake = 1'h0;
    chk(o_wake_irq && o_bus_rxd_low && o_wdog_long_window, "bus wake");
    host.send(1, '0);
    chk(!o_bus_rxd_low && o_mode === SSF_NORMAL, "normal");
    $display("end stop_wake");
  endtask : t_stop_wake
  task automatic t_uv_short;
    i_main_below_reset = 1'h1;
    @(negedge i_sys_clk);
    chk(!o_reset_out_n && o_mode === SSF_RESTART, "uv reset");
    i_main_below_reset = 1'h0;
    await(4'hF, {1'h1, SSF_NORMAL});
    chk(o_flags.main_undervolt_flag === 1'h1, "uv flag");
    i_main_below_reset = 1'h1;
    await(4'h7, {1'h0, SSF_FAILSAFE});
    chk(o_fail_output && !o_main_reg_en && o_flags.main_short_flag &&
      o_flags.failure, "short");
    i_wake_input = 1'h1;
    @(negedge i_sys_clk);
    chk(o_mode === SSF_RESTART, "wake");
    {i_main_below_reset, i_wake_input, i_batt_above_por} = 3'h0;
    @(negedge i_sys_clk);
    chk(o_mode === SSF_INIT && !o_reset_out_n, "supply drop");
    $display("end uv_short");
  endtask : t_uv_short
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_reset_out_n = 1'h1;
    @(negedge i_sys_clk);
    t_power_up();
    t_flags();
    t_bus_ot();
    t_stop_wake();
    t_uv_short();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
